// file: core/pmicil_defines.svh
// register offsets, field positions, reset values and timing counts of the event-latch bank
// assumes inclusion by bare name from the synchroniser and top files of the bank
`ifndef PMICIL_DEFINES_SVH
`define PMICIL_DEFINES_SVH

// register offsets on the serial register port
`define PMICIL_SOFTWARE_RESET_BIT_OFFSET   8'h18
`define PMICIL_TOP_OFFSET        8'h19
`define PMICIL_RESET_EVT_OFFSET  8'h1A
`define PMICIL_CONV_OFFSET       8'h1B
`define PMICIL_REG_OFFSET        8'h1C

// top event register fields
`define PMICIL_TOP_POWERGOOD_PIN_BIT     7
`define PMICIL_TOP_REG_SUM_BIT   6
`define PMICIL_TOP_CONV_SUM_BIT  5
`define PMICIL_TOP_CLK_BIT       4
`define PMICIL_TOP_TSD_BIT       3
`define PMICIL_TOP_TWARN_BIT     2
`define PMICIL_TOP_OVP_BIT       1
`define PMICIL_TOP_MEAS_BIT      0

// reset event and software reset fields
`define PMICIL_RESET_EVT_BIT     0
`define PMICIL_SOFTWARE_RESET_BIT_BIT      0

// per-rail event register fields, same layout for converters and regulators
`define PMICIL_RAIL1_PG_BIT      6
`define PMICIL_RAIL1_SC_BIT      5
`define PMICIL_RAIL1_LIM_BIT     4
`define PMICIL_RAIL0_PG_BIT      2
`define PMICIL_RAIL0_SC_BIT      1
`define PMICIL_RAIL0_LIM_BIT     0

// reset values and writable masks
`define PMICIL_EVT_RESET         8'h00
`define PMICIL_RESET_EVT_SET     8'h01
`define PMICIL_TOP_LATCH_MASK    8'h9F
`define PMICIL_RESET_EVT_MASK    8'h01
`define PMICIL_RAIL_EVT_MASK     8'h77

// timing
`define PMICIL_CLK_PERIOD_NS     5
`define PMICIL_SHORT_TIME_NS     1000000
`define PMICIL_SHORT_CYCLES      ((`PMICIL_SHORT_TIME_NS + `PMICIL_CLK_PERIOD_NS - 1) / `PMICIL_CLK_PERIOD_NS)

// number of asynchronous monitor inputs passed through the synchroniser
`define PMICIL_SYNC_WIDTH        18

`endif

// file: core/pmicil_pkg.sv
// types shared by the event-latch bank
// assumes nothing beyond a SystemVerilog compiler
package pmicil_pkg;

    typedef logic [7:0] pmicil_byte_t;
    typedef logic [3:0] pmicil_rail_t;

    // reset event sequence
    typedef enum logic [1:0] {
        PMICIL_SEQ_IDLE  = 2'b00,
        PMICIL_SEQ_CLEAR = 2'b01,
        PMICIL_SEQ_START = 2'b10
    } pmicil_seq_e;

endpackage : pmicil_pkg

// file: core/pmicil_sync.sv
// two-flop synchroniser for the analog monitor inputs
// assumes inputs come from outside the clk_sys domain
`include "pmicil_defines.svh"
module pmicil_sync
    import pmicil_pkg::*;
#(
    parameter int WIDTH = `PMICIL_SYNC_WIDTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : pmicil_sync

// file: core/pmicil_short_timer.sv
// short-circuit qualifier: one pulse after an output stays low longer than the set time
// assumes low is already synchronised to clk_sys
module pmicil_short_timer
    import pmicil_pkg::*;
#(
    parameter int unsigned CYCLES = 200000
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic low,
    output logic      fire
);

    logic [31:0] cnt_q;
    logic        fired_q;

    // count low cycles, fire once per low episode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q   <= 32'h0000_0000;
            fired_q <= 1'b0;
        end else if (!low) begin
            cnt_q   <= 32'h0000_0000;
            fired_q <= 1'b0;
        end else if (!fired_q) begin
            if (cnt_q == 32'(CYCLES)) begin
                fired_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 32'h0000_0001;
            end
        end
    end

    assign fire = low && !fired_q && (cnt_q == 32'(CYCLES));

    a_short_once_per_low : assert property (@(posedge clk_sys) disable iff (rst)
        fire |=> !fire throughout (low [*1])) else $error("short pulse repeated");
    a_short_needs_time : assert property (@(posedge clk_sys) disable iff (rst)
        fire |-> $past(low) && cnt_q != 32'h0000_0000) else $error("short fired early");

endmodule : pmicil_short_timer

// file: core/pmicil_top.sv
// event-latch bank of the power manager: top, reset, converter and regulator event registers
// assumes a serial register port on clk_sys and asynchronous analog monitor inputs
`include "pmicil_defines.svh"
module pmicil_top
    import pmicil_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = `PMICIL_SHORT_CYCLES
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire pmicil_byte_t reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire pmicil_byte_t reg_wdata,
    output pmicil_byte_t      reg_rdata,
    input  wire logic         powergood_pin,
    input  wire logic         sync_clock_valid,
    input  wire logic         thermal_shutdown_live,
    input  wire logic         thermal_warning_live,
    input  wire logic         overvoltage_live,
    input  wire logic         analog_supply_low,
    input  wire pmicil_rail_t rail_pg_bad,
    input  wire pmicil_rail_t rail_short_low,
    input  wire pmicil_rail_t rail_limit_live,
    input  wire logic         measurement_done,
    input  wire pmicil_rail_t rail_enable_req,
    input  wire logic         general_output_a_req,
    input  wire logic         general_output_b_req,
    input  wire pmicil_byte_t top_mask,
    input  wire logic         reset_mask,
    input  wire pmicil_byte_t conv_mask,
    input  wire pmicil_byte_t reg_mask,
    output pmicil_rail_t      rail_enable,
    output logic              general_output_a,
    output logic              general_output_b,
    output logic              irq,
    output logic              startup_req,
    output logic              serial_reset_req
);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////////////
    // helpers

    // write decode for one register offset
    function automatic logic addr_hit(input logic wr, input pmicil_byte_t addr,
                                      input pmicil_byte_t off);
        return wr && (addr == off);
    endfunction : addr_hit

    // write-one-to-clear update, a set in the same cycle wins
    function automatic pmicil_byte_t w1c(input pmicil_byte_t cur, input pmicil_byte_t set,
                                         input logic hit, input pmicil_byte_t wdata,
                                         input pmicil_byte_t valid);
        pmicil_byte_t clr;
        clr = hit ? wdata : `PMICIL_EVT_RESET;
        return (set | (cur & ~clr)) & valid;
    endfunction : w1c

    // place the event pulses of a rail pair into their register layout
    function automatic pmicil_byte_t rail_pack(input logic [1:0] pg, input logic [1:0] sc,
                                               input logic [1:0] lim);
        pmicil_byte_t b;
        b = `PMICIL_EVT_RESET;
        b[`PMICIL_RAIL1_PG_BIT]  = pg[1];
        b[`PMICIL_RAIL1_SC_BIT]  = sc[1];
        b[`PMICIL_RAIL1_LIM_BIT] = lim[1];
        b[`PMICIL_RAIL0_PG_BIT]  = pg[0];
        b[`PMICIL_RAIL0_SC_BIT]  = sc[0];
        b[`PMICIL_RAIL0_LIM_BIT] = lim[0];
        return b;
    endfunction : rail_pack

    ////////////////////////////////////////////////////////////////////////////////////////
    // input synchronisation and edge detection

    logic [17:0]  sync_s;
    logic [9:0]   prev_q;
    logic         powergood_pin_s;
    logic         clkv_s;
    logic         tsd_s;
    logic         twarn_s;
    logic         ovp_s;
    logic         uv_s;
    pmicil_rail_t pg_bad_s;
    pmicil_rail_t short_s;
    pmicil_rail_t limit_s;

    pmicil_sync #(
        .WIDTH    (`PMICIL_SYNC_WIDTH)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in ({powergood_pin, sync_clock_valid, thermal_shutdown_live,
                    thermal_warning_live, overvoltage_live, analog_supply_low,
                    rail_pg_bad, rail_short_low, rail_limit_live}),
        .sync_out (sync_s)
    );

    // unpack the synchronised monitors
    assign {powergood_pin_s, clkv_s, tsd_s, twarn_s, ovp_s, uv_s, pg_bad_s, short_s, limit_s} = sync_s;

    // previous values for edge detection
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_q <= 10'h000;
        end else begin
            prev_q <= {powergood_pin_s, clkv_s, tsd_s, twarn_s, ovp_s, uv_s, pg_bad_s};
        end
    end

    logic         powergood_pin_fall;
    logic         clk_edge;
    logic         tsd_rise;
    logic         twarn_rise;
    logic         ovp_rise;
    logic         uv_rise;
    pmicil_rail_t pg_rise;
    pmicil_rail_t short_fire;

    // event pulses from the monitors
    assign powergood_pin_fall = prev_q[9] && !powergood_pin_s;
    assign clk_edge   = prev_q[8] ^ clkv_s;
    assign tsd_rise   = !prev_q[7] && tsd_s;
    assign twarn_rise = !prev_q[6] && twarn_s;
    assign ovp_rise   = !prev_q[5] && ovp_s;
    assign uv_rise    = !prev_q[4] && uv_s;
    assign pg_rise    = ~prev_q[3:0] & pg_bad_s;

    // one short-circuit qualifier per rail: 0 conv0, 1 conv1, 2 reg0, 3 reg1
    for (genvar r = 0; r < 4; r++) begin : g_short
        pmicil_short_timer #(
            .CYCLES  (SHORT_CYCLES)
        ) u_short (
            .clk_sys (clk_sys),
            .rst     (rst),
            .low     (short_s[r]),
            .fire    (short_fire[r])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // reset event sequence

    pmicil_seq_e seq_q;
    pmicil_seq_e seq_d;
    logic        soft_trig;
    logic        reset_trig;
    logic        bank_clear;

    assign soft_trig  = addr_hit(reg_wr, reg_addr, `PMICIL_SOFTWARE_RESET_BIT_OFFSET)
                        && reg_wdata[`PMICIL_SOFTWARE_RESET_BIT_BIT];
    assign reset_trig = soft_trig || uv_rise;
    assign bank_clear = (seq_q == PMICIL_SEQ_CLEAR);

    // clear the bank, then request the startup procedure
    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            PMICIL_SEQ_IDLE:  if (reset_trig) seq_d = PMICIL_SEQ_CLEAR;
            PMICIL_SEQ_CLEAR: seq_d = PMICIL_SEQ_START;
            PMICIL_SEQ_START: seq_d = reset_trig ? PMICIL_SEQ_CLEAR : PMICIL_SEQ_IDLE;
            default:          seq_d = PMICIL_SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seq_q <= PMICIL_SEQ_IDLE;
        end else begin
            seq_q <= seq_d;
        end
    end

    assign startup_req = (seq_q == PMICIL_SEQ_START);

    // serial port reset pulse on a software reset write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            serial_reset_req <= 1'b0;
        end else begin
            serial_reset_req <= soft_trig;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // event registers

    pmicil_byte_t top_q;
    pmicil_byte_t reset_q;
    pmicil_byte_t conv_q;
    pmicil_byte_t reg_q;
    pmicil_byte_t top_set;
    pmicil_byte_t conv_set;
    pmicil_byte_t reg_set;

    // set vectors of the top, converter and regulator registers
    always_comb begin
        top_set                        = `PMICIL_EVT_RESET;
        top_set[`PMICIL_TOP_POWERGOOD_PIN_BIT] = powergood_pin_fall;
        top_set[`PMICIL_TOP_CLK_BIT]   = clk_edge;
        top_set[`PMICIL_TOP_TSD_BIT]   = tsd_rise;
        top_set[`PMICIL_TOP_TWARN_BIT] = twarn_rise;
        top_set[`PMICIL_TOP_OVP_BIT]   = ovp_rise;
        top_set[`PMICIL_TOP_MEAS_BIT]  = measurement_done;
    end

    assign conv_set = rail_pack(pg_rise[1:0], short_fire[1:0], limit_s[1:0]);
    assign reg_set  = rail_pack(pg_rise[3:2], short_fire[3:2], limit_s[3:2]);

    // top latched bits, summaries are not stored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            top_q <= `PMICIL_EVT_RESET;
        end else if (bank_clear) begin
            top_q <= `PMICIL_EVT_RESET;
        end else begin
            top_q <= w1c(top_q, top_set, addr_hit(reg_wr, reg_addr, `PMICIL_TOP_OFFSET),
                         reg_wdata, `PMICIL_TOP_LATCH_MASK);
        end
    end

    // reset event register, set by the bank clear itself
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reset_q <= `PMICIL_EVT_RESET;
        end else if (bank_clear) begin
            reset_q <= `PMICIL_RESET_EVT_SET;
        end else begin
            reset_q <= w1c(reset_q, `PMICIL_EVT_RESET,
                           addr_hit(reg_wr, reg_addr, `PMICIL_RESET_EVT_OFFSET),
                           reg_wdata, `PMICIL_RESET_EVT_MASK);
        end
    end

    // converter and regulator event registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conv_q <= `PMICIL_EVT_RESET;
            reg_q  <= `PMICIL_EVT_RESET;
        end else if (bank_clear) begin
            conv_q <= `PMICIL_EVT_RESET;
            reg_q  <= `PMICIL_EVT_RESET;
        end else begin
            conv_q <= w1c(conv_q, conv_set, addr_hit(reg_wr, reg_addr, `PMICIL_CONV_OFFSET),
                          reg_wdata, `PMICIL_RAIL_EVT_MASK);
            reg_q  <= w1c(reg_q, reg_set, addr_hit(reg_wr, reg_addr, `PMICIL_REG_OFFSET),
                          reg_wdata, `PMICIL_RAIL_EVT_MASK);
        end
    end

    pmicil_byte_t top_view;

    // top register as read, summaries follow the rail registers
    always_comb begin
        top_view                          = top_q;
        top_view[`PMICIL_TOP_REG_SUM_BIT]  = |reg_q;
        top_view[`PMICIL_TOP_CONV_SUM_BIT] = |conv_q;
    end

    // registered read data, unmapped offsets and the reset command read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= `PMICIL_EVT_RESET;
        end else if (reg_rd) begin
            case (reg_addr)
                `PMICIL_TOP_OFFSET:       reg_rdata <= top_view;
                `PMICIL_RESET_EVT_OFFSET: reg_rdata <= reset_q;
                `PMICIL_CONV_OFFSET:      reg_rdata <= conv_q;
                `PMICIL_REG_OFFSET:       reg_rdata <= reg_q;
                default:                  reg_rdata <= `PMICIL_EVT_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // protection actions and interrupt

    logic         trip;
    pmicil_rail_t hold_q;

    assign trip = tsd_rise || ovp_rise || bank_clear;

    // a tripped rail stays off until its request is withdrawn
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_q <= 4'h0;
        end else if (trip) begin
            hold_q <= 4'hF;
        end else begin
            hold_q <= hold_q & rail_enable_req;
        end
    end

    // rail enables and general outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rail_enable      <= 4'h0;
            general_output_a <= 1'b0;
            general_output_b <= 1'b0;
        end else begin
            rail_enable      <= rail_enable_req & ~hold_q & ~{4{trip}}
                                & ~{4{top_q[`PMICIL_TOP_TSD_BIT]}};
            general_output_a <= general_output_a_req && !trip
                                && !top_q[`PMICIL_TOP_TSD_BIT] && !top_q[`PMICIL_TOP_OVP_BIT];
            general_output_b <= general_output_b_req && !trip
                                && !top_q[`PMICIL_TOP_TSD_BIT] && !top_q[`PMICIL_TOP_OVP_BIT];
        end
    end

    logic pending;

    assign pending = |(top_q & ~top_mask) || (reset_q[`PMICIL_RESET_EVT_BIT] && !reset_mask)
                     || |(conv_q & ~conv_mask) || |(reg_q & ~reg_mask);

    // interrupt level, one cycle behind the latches
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // checks

    a_reg_summary_read : assert property (reg_rd && reg_addr == `PMICIL_TOP_OFFSET |=>
        reg_rdata[6] == ($past(reg_q) != 8'h00)) else $error("regulator summary wrong");
    a_conv_summary_read : assert property (reg_rd && reg_addr == `PMICIL_TOP_OFFSET |=>
        reg_rdata[5] == ($past(conv_q) != 8'h00)) else $error("converter summary wrong");
    a_clk_edge_latch : assert property (clk_edge && !bank_clear |=> top_q[4])
        else $error("clock presence change lost");
    a_tsd_shutdown : assert property (tsd_rise |=> rail_enable == 4'h0 && !general_output_a
        && !general_output_b && top_q[3]) else $error("thermal shutdown not acted on");
    a_tsd_refuse : assert property (top_q[3] |=> rail_enable == 4'h0)
        else $error("rail enabled during thermal shutdown");
    a_twarn_latch : assert property (twarn_rise && !bank_clear |=> top_q[2])
        else $error("thermal warning lost");
    a_ovp_shutdown : assert property (ovp_rise |=> rail_enable == 4'h0 && !general_output_a
        && !general_output_b && top_q[1]) else $error("overvoltage not acted on");
    a_meas_latch : assert property (measurement_done && !bank_clear |=> top_q[0])
        else $error("measurement ready lost");
    a_reset_sequence : assert property (reset_trig && seq_q == PMICIL_SEQ_IDLE |=> bank_clear
        ##1 (reset_q == 8'h01 && conv_q == 8'h00 && reg_q == 8'h00 && startup_req)
        ##1 !startup_req || bank_clear) else $error("reset sequence wrong");
    a_conv_set_wins : assert property (conv_set != 8'h00 && !bank_clear |=>
        (conv_q & $past(conv_set)) == $past(conv_set)) else $error("converter event lost");
    a_conv_short_bits : assert property (short_fire[1] && !bank_clear |=> conv_q[5])
        else $error("converter short lost");
    a_conv_limit_bits : assert property (limit_s[0] && !bank_clear |=> conv_q[0])
        else $error("converter limit lost");
    a_reg_set_wins : assert property (reg_set != 8'h00 && !bank_clear |=>
        (reg_q & $past(reg_set)) == $past(reg_set)) else $error("regulator event lost");
    a_reg_limit_bits : assert property (limit_s[3] && !bank_clear |=> reg_q[4])
        else $error("regulator limit lost");
    a_w1c_clear : assert property (reg_wr && reg_addr == `PMICIL_CONV_OFFSET && conv_set == 8'h00
        && !bank_clear |=> (conv_q & $past(reg_wdata)) == 8'h00
        && (conv_q | $past(reg_wdata)) == ($past(conv_q) | $past(reg_wdata)))
        else $error("write one to clear wrong");
    a_reserved_zero : assert property ((reset_q & 8'hFE) == 8'h00 && (conv_q & 8'h88) == 8'h00
        && (reg_q & 8'h88) == 8'h00) else $error("reserved bit set");
    a_powergood_pin_fall : assert property ($fell(powergood_pin_s) && !bank_clear |=> top_q[7])
        else $error("power-good drop lost");
    a_soft_reset : assert property (soft_trig |=> serial_reset_req ##1 !serial_reset_req
        || soft_trig) else $error("software reset pulse wrong");
    a_irq_follows : assert property (##1 irq == $past(pending))
        else $error("interrupt level wrong");

    c_tsd_trip : cover property (tsd_rise ##1 rail_enable == 4'h0);
    c_reset_seq : cover property (uv_rise ##2 startup_req);
    c_short_fire : cover property (short_fire[2] ##1 reg_q[1]);
    c_w1c_clear : cover property (conv_q[6] ##1 reg_wr && reg_addr == `PMICIL_CONV_OFFSET
        ##1 !conv_q[6]);

endmodule : pmicil_top

// file: verif/pmicil_host.sv
// host model: master of the register port of the event-latch bank
// assumes the bank samples on rising clk_sys; strobes change at falling edges
module pmicil_host
    import pmicil_pkg::*;
(
    input  wire logic         clk_sys,
    output pmicil_byte_t      reg_addr,
    output logic              reg_wr,
    output logic              reg_rd,
    output pmicil_byte_t      reg_wdata,
    input  wire pmicil_byte_t reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus, no strobe
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    end
    // one write strobe; a 1 clears that event bit
    task automatic wr(input pmicil_byte_t a, input pmicil_byte_t d);
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask : wr
    // one read strobe; data taken one and a half cycles after the read edge
    task automatic rd(input pmicil_byte_t a, output pmicil_byte_t d);
        @(negedge clk_sys);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk_sys);
        {reg_addr, reg_rd} = {~a, 1'b0};
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : rd
endmodule : pmicil_host

// file: verif/pmic_interrupt_latches_test.sv
// self-checking bench of the event-latch bank
// assumes a short-circuit time shortened to SC cycles
module pmic_interrupt_latches_test
    import pmicil_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SC = 10;
    logic         clk_sys, rst, reg_wr, reg_rd, pg, ck, tsd, tw, ov, uv, md, ga, gb, go_a, go_b;
    logic         irq_o, start_o, sreset_o;
    pmicil_byte_t reg_addr, reg_wdata, reg_rdata, v;
    pmicil_rail_t pgb, scl, lim, req, ren;
    int           n_errors, samples_checked, cycles;
    pmicil_host i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    pmicil_top #(.SHORT_CYCLES(SC)) i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .powergood_pin(pg), .sync_clock_valid(ck), .thermal_shutdown_live(tsd),
        .thermal_warning_live(tw), .overvoltage_live(ov), .analog_supply_low(uv),
        .rail_pg_bad(pgb), .rail_short_low(scl), .rail_limit_live(lim), .measurement_done(md),
        .rail_enable_req(req), .general_output_a_req(ga), .general_output_b_req(gb),
        .top_mask(8'h00), .reset_mask(1'b0), .conv_mask(8'h00), .reg_mask(8'h00),
        .rail_enable(ren), .general_output_a(go_a), .general_output_b(go_b), .irq(irq_o),
        .startup_req(start_o), .serial_reset_req(sreset_o));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, 5 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : w
    task automatic chk(input pmicil_byte_t got, input pmicil_byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input pmicil_byte_t a, input pmicil_byte_t exp);
        i_host.rd(a, v);
        chk(v, exp);
    endtask : rchk
    ////////////////////////////////////////////////////////////////////////////////
    // defaults, reserved bits, unmapped place
    task automatic t_defaults();
        foreach (v[i]) rchk(8'h19 + i[7:0] % 8'h4, 8'h00);
        i_host.wr(8'h1C, 8'hFF);
        rchk(8'h1C, 8'h00);
        rchk(8'h30, 8'h00);
    endtask : t_defaults
    // thermal shutdown forces rails and outputs off until cleared
    task automatic t_thermal();
        {req, ga, gb} = 6'h3F;
        w(4);
        chk({ren, go_a, go_b}, 8'h3F);
        tsd = 1'b1;
        w(6);
        chk({ren, go_a, go_b}, 8'h00);
        rchk(8'h19, 8'h08);
        tsd = 1'b0;
        req = 4'h0;
        w(2);
        req = 4'hF;
        w(3);
        chk({4'h0, ren}, 8'h00);
        i_host.wr(8'h19, 8'h08);
        {req, ga, gb} = 6'h00;
        w(2);
        {req, ga, gb} = 6'h3F;
        w(3);
        chk({ren, go_a, go_b}, 8'h3F);
    endtask : t_thermal
    // converter 1 current limit and converter summary
    task automatic t_limit();
        lim = 4'h2;
        w(1);
        lim = 4'h0;
        w(5);
        rchk(8'h1B, 8'h10);
        rchk(8'h19, 8'h20);
        chk({7'h00, irq_o}, 8'h01);
        i_host.wr(8'h1B, 8'h10);
        rchk(8'h19, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
    endtask : t_limit
    // measurement, clock change, warning and overvoltage latch in the top register
    task automatic t_events();
        md = 1'b1;
        w(1);
        md = 1'b0;
        rchk(8'h19, 8'h01);
        {ck, tw, ov} = 3'h7;
        w(5);
        chk({6'h00, go_a, go_b}, 8'h00);
        rchk(8'h19, 8'h17);
        i_host.wr(8'h19, 8'h17);
        rchk(8'h19, 8'h00);
    endtask : t_events
    // regulator 0 short: too brief, then long enough
    task automatic t_short();
        scl = 4'h4;
        w(SC - 4);
        scl = 4'h0;
        w(6);
        rchk(8'h1C, 8'h00);
        scl = 4'h4;
        w(SC + 8);
        scl = 4'h0;
        rchk(8'h1C, 8'h02);
        rchk(8'h19, 8'h40);
    endtask : t_short
    // software reset defaults the bank and leaves the reset event set
    task automatic t_reset();
        i_host.wr(8'h18, 8'h01);
        chk({7'h00, sreset_o}, 8'h01);
        w(1);
        chk({7'h00, start_o}, 8'h01);
        chk({4'h0, ren}, 8'h00);
        w(3);
        rchk(8'h1A, 8'h01);
        rchk(8'h1C, 8'h00);
        i_host.wr(8'h1A, 8'h01);
        rchk(8'h1A, 8'h00);
    endtask : t_reset
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // main sequence
    initial begin
        {rst, pg, ck, tsd, tw, ov, uv, md, ga, gb, pgb, scl, lim, req} = 26'h2000000;
        w(12);
        rst = 1'b0;
        t_defaults();
        t_thermal();
        t_limit();
        t_events();
        t_short();
        t_reset();
        print_verdict();
    end
endmodule : pmic_interrupt_latches_test
